/* File: mtx_pkg.sv */
// Purpose: shared constants and types of the mii transmit / receive-error block
// Assumes: link reference clock of LINK_REF_HZ feeds the link domain
// Notes:   one name for every figure used by the logic, apart from the mtx_enc code groups
`default_nettype none
package mtx_pkg;
    localparam int LINK_REF_HZ   = 50_000_000;
    localparam int TXCLK_10M_HZ  = 2_500_000;
    localparam int TXCLK_100M_HZ = 25_000_000;
    localparam int DIV_W         = 4;
    localparam logic [DIV_W-1:0] HALF_10 =
        DIV_W'(LINK_REF_HZ / (2 * TXCLK_10M_HZ));
    localparam logic [DIV_W-1:0] HALF_100 =
        DIV_W'(LINK_REF_HZ / (2 * TXCLK_100M_HZ));
    localparam logic [DIV_W-1:0] DIV_ONE  = 4'h1;
    localparam logic [DIV_W-1:0] DIV_ZERO = 4'h0;
    localparam int SYM_W     = 5;
    localparam int NIB_W     = 4;
    localparam int CFG_W     = 7;
    localparam int CFG_SPEED = 6;
    localparam int CFG_TEST  = 5;
    localparam int CFG_SYM   = 0;
    localparam logic [SYM_W-1:0] SYM_HALT = 5'h04;
    localparam logic [SYM_W-1:0] SYM_IDLE = 5'h1f;
    localparam logic [SYM_W-1:0] SYM_ZERO = 5'h00;
    localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
    localparam logic [CFG_W-1:0] CFG_RST  = 7'h40;
    typedef enum logic [0:0] {MTX_TX_IDLE, MTX_TX_FRAME} mtx_tx_type;
    typedef enum logic [1:0] {MTX_RX_IDLE, MTX_RX_FRAME, MTX_RX_FALSE} mtx_rx_type;
    function automatic logic [SYM_W-1:0] mtx_enc(input logic [NIB_W-1:0] n);
        logic [SYM_W-1:0] s;
        s = SYM_IDLE;
        case (n)
            4'h0: s = 5'h1e;
            4'h1: s = 5'h09;
            4'h2: s = 5'h14;
            4'h3: s = 5'h15;
            4'h4: s = 5'h0a;
            4'h5: s = 5'h0b;
            4'h6: s = 5'h0e;
            4'h7: s = 5'h0f;
            4'h8: s = 5'h12;
            4'h9: s = 5'h13;
            4'ha: s = 5'h16;
            4'hb: s = 5'h17;
            4'hc: s = 5'h1a;
            4'hd: s = 5'h1b;
            4'he: s = 5'h1c;
            4'hf: s = 5'h1d;
            default: s = SYM_IDLE;
        endcase
        return s;
    endfunction
endpackage
`default_nettype wire

/* File: mtx_sync3.sv */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: d comes from another clock domain or a pin
// Notes:   q moves only when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module mtx_sync3 #(
    parameter int W = 1
) (
    input  wire logic         clk,    // destination clock
    input  wire logic         rst_n,  // async reset, low
    input  wire logic [W-1:0] d,      // foreign level
    output var  logic [W-1:0] q       // filtered level
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (s2_reg == s3_reg) begin
            q <= s3_reg;
        end
    end
endmodule
`default_nettype wire

/* File: mtx_mii_phy.sv */
// How it works
// RL1: rxer unused at ten megabit
// RL2: rxer flags errors inside valid frame
// RL3: rxer flags false carrier at hundred
// RL4: rxer changes only on rxclk rise
// RL5: rxer released under tristate request
// RL6: tristate high releases whole receive side
// RL7: txclk 2.5 or 25 MHz by mode
// RL8: txd0 is nibble lsb
// RL9: txd sampled each txclk rise when enabled
// RL10: txen starts sampling and transmitting nibbles
// RL11: txen low ends transmission
// RL12: txer ignored at ten megabit
// RL13: txer sampled on txclk rise at hundred
// RL14: txer substitutes halt symbol
// RL15: test bit substitutes configured symbol
// RL16: rxclk 2.5 or 25 MHz by mode
// RL17: rxdv on start delimiter, off on end/error
// RL18: rxer held low at ten megabit
// RL19: txer has no effect while idle
//
// Purpose: phy side of mii transmit path plus receive error and tristate
// Assumes: LINK_CLK is a 50 MHz reference; rx event inputs are link-domain pulses
// Notes:   config from CLK side crosses by toggle handshake; no J/K framing here
`timescale 1ns/1ns
`default_nettype none
module mtx_mii_phy
    import mtx_pkg::*;
(
    input  wire logic             CLK,          // management clock
    input  wire logic             ARST_N,       // async reset, low
    input  wire logic             SPEED_100,    // 1: 100base-tx, 0: 10base-t
    input  wire logic             TEST_CODE_EN, // invalid error code test
    input  wire logic [SYM_W-1:0] TEST_SYMBOL,  // symbol used under test
    output var  logic             CFG_BUSY,     // config crossing in flight
    output var  logic             TX_ACTIVE,    // transmit busy, CLK side
    input  wire logic             LINK_CLK,     // link reference clock
    output var  logic             TXCLK,        // transmit clock to mac
    input  wire logic             TXEN,         // transmit enable
    input  wire logic [NIB_W-1:0] TXD,          // transmit nibble
    input  wire logic             TXER,         // transmit error
    output var  logic [SYM_W-1:0] TX_SYM,       // code group to media
    output var  logic             TX_SYM_VALID, // code group strobe
    output var  logic             TX_ON_LINE,   // transmission in progress
    input  wire logic             RX_SSD_DET,   // start delimiter recovered
    input  wire logic             RX_ESD_DET,   // end delimiter seen
    input  wire logic             RX_SIG_ERR,   // signal error, ends frame
    input  wire logic             RX_CODE_ERR,  // code error in frame
    input  wire logic             RX_FALSE_CAR, // false carrier seen
    input  wire logic             RECEIVE_TRISTATE_REQUEST, // mac tristate
    output var  logic             RXCLK_O,      // receive clock level
    output var  logic             RXCLK_OE,     // receive clock drive
    output var  logic             RXDV_O,       // receive data valid
    output var  logic             RXDV_OE,      // receive valid drive
    output var  logic             RXER_O,       // receive error
    output var  logic             RXER_OE       // receive error drive
);
    logic [CFG_W-1:0] cfg_word_reg;
    logic [CFG_W-1:0] cfg_live;
    logic             req_tgl_reg;
    logic             ack_seen;
    logic             tx_busy_seen;
    logic             lrst1_reg;
    logic             lrst_n_reg;
    logic             req_seen;
    logic             req_done_reg;
    logic             ack_tgl_reg;
    logic [CFG_W-1:0] lcfg_reg;
    logic             tri_req;
    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] half;
    logic             rise;
    logic             speed;
    mtx_tx_type       tx_state_reg;
    mtx_rx_type       rx_state_reg;
    logic             ssd_pend_reg;
    logic             end_pend_reg;
    logic             err_pend_reg;
    logic             fc_pend_reg;
    logic             rxer_next;

    // ---------------- CLK domain ----------------
    assign cfg_live = {SPEED_100, TEST_CODE_EN, TEST_SYMBOL};

    // a new word launches only after the previous one is acknowledged
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cfg_word_reg <= CFG_RST;
            req_tgl_reg  <= 1'b0;
        end else if (req_tgl_reg == ack_seen && cfg_live != cfg_word_reg) begin
            cfg_word_reg <= cfg_live;
            req_tgl_reg  <= ~req_tgl_reg;
        end
    end

    mtx_sync3 #(.W(1)) u_ack_sync (
        .clk   (CLK),
        .rst_n (ARST_N),
        .d     (ack_tgl_reg),
        .q     (ack_seen)
    );

    mtx_sync3 #(.W(1)) u_busy_sync (
        .clk   (CLK),
        .rst_n (ARST_N),
        .d     (TX_ON_LINE),
        .q     (tx_busy_seen)
    );

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CFG_BUSY  <= 1'b0;
            TX_ACTIVE <= 1'b0;
        end else begin
            CFG_BUSY  <= (req_tgl_reg != ack_seen);
            TX_ACTIVE <= tx_busy_seen;
        end
    end

    // ---------------- link domain ----------------
    // reset released synchronously so the divider starts cleanly
    always_ff @(posedge LINK_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            lrst1_reg  <= 1'b0;
            lrst_n_reg <= 1'b0;
        end else begin
            lrst1_reg  <= 1'b1;
            lrst_n_reg <= lrst1_reg;
        end
    end

    mtx_sync3 #(.W(1)) u_req_sync (
        .clk   (LINK_CLK),
        .rst_n (lrst_n_reg),
        .d     (req_tgl_reg),
        .q     (req_seen)
    );

    // word is stable while the toggle is in flight, so a bus capture is safe
    always_ff @(posedge LINK_CLK or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            lcfg_reg     <= CFG_RST;
            req_done_reg <= 1'b0;
            ack_tgl_reg  <= 1'b0;
        end else if (req_seen != req_done_reg) begin
            lcfg_reg     <= cfg_word_reg;
            req_done_reg <= req_seen;
            ack_tgl_reg  <= req_seen;
        end
    end

    mtx_sync3 #(.W(1)) u_tri_sync (
        .clk   (LINK_CLK),
        .rst_n (lrst_n_reg),
        .d     (RECEIVE_TRISTATE_REQUEST),
        .q     (tri_req)
    );

    assign speed = lcfg_reg[CFG_SPEED];
    assign half  = speed ? HALF_100 : HALF_10;                     // RL7 RL16
    assign rise  = (div_reg >= half - DIV_ONE) && !TXCLK;

    // one divider drives both clocks; rx recovery is outside this block
    always_ff @(posedge LINK_CLK or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            div_reg <= DIV_ZERO;
            TXCLK   <= 1'b0;
            RXCLK_O <= 1'b0;
        end else if (div_reg >= half - DIV_ONE) begin
            div_reg <= DIV_ZERO;
            TXCLK   <= ~TXCLK;                                     // RL7
            RXCLK_O <= ~TXCLK;                                     // RL16
        end else begin
            div_reg <= div_reg + DIV_ONE;
        end
    end

    // transmit: the mac is on our txclk, so its pins need no crossing
    always_ff @(posedge LINK_CLK or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            tx_state_reg <= MTX_TX_IDLE;
            TX_ON_LINE   <= 1'b0;
        end else if (rise) begin
            case (tx_state_reg)
                MTX_TX_IDLE: begin
                    if (TXEN) begin
                        tx_state_reg <= MTX_TX_FRAME;              // RL10
                        TX_ON_LINE   <= 1'b1;
                    end
                end
                MTX_TX_FRAME: begin
                    if (!TXEN) begin
                        tx_state_reg <= MTX_TX_IDLE;               // RL11
                        TX_ON_LINE   <= 1'b0;
                    end
                end
                default: begin
                    tx_state_reg <= MTX_TX_IDLE;
                    TX_ON_LINE   <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge LINK_CLK or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            TX_SYM       <= SYM_IDLE;
            TX_SYM_VALID <= 1'b0;
        end else if (rise && TXEN) begin
            TX_SYM_VALID <= 1'b1;                                  // RL9
            if (!speed) begin
                TX_SYM <= {1'b0, TXD};                             // RL8 RL12
            end else if (TXER && lcfg_reg[CFG_TEST]) begin
                TX_SYM <= lcfg_reg[CFG_SYM +: SYM_W];              // RL15
            end else if (TXER) begin
                TX_SYM <= SYM_HALT;                                // RL13 RL14
            end else begin
                TX_SYM <= mtx_enc(TXD);                            // RL8
            end
        end else if (rise) begin
            TX_SYM       <= SYM_IDLE;                              // RL19
            TX_SYM_VALID <= 1'b0;
        end else begin
            TX_SYM_VALID <= 1'b0;
        end
    end

    // receive events are held until the next rxclk rise; set beats clear
    always_ff @(posedge LINK_CLK or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            ssd_pend_reg <= 1'b0;
            end_pend_reg <= 1'b0;
            err_pend_reg <= 1'b0;
            fc_pend_reg  <= 1'b0;
        end else begin
            ssd_pend_reg <= RX_SSD_DET   || (ssd_pend_reg && !rise);
            end_pend_reg <= RX_ESD_DET || RX_SIG_ERR || (end_pend_reg && !rise);
            err_pend_reg <= RX_CODE_ERR  || (err_pend_reg && !rise);
            fc_pend_reg  <= RX_FALSE_CAR || (fc_pend_reg && !rise);
        end
    end

    always_ff @(posedge LINK_CLK or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            rx_state_reg <= MTX_RX_IDLE;
        end else if (rise) begin
            case (rx_state_reg)
                MTX_RX_IDLE: begin
                    if (ssd_pend_reg) begin
                        rx_state_reg <= MTX_RX_FRAME;              // RL17
                    end else if (fc_pend_reg && speed) begin
                        rx_state_reg <= MTX_RX_FALSE;              // RL3
                    end
                end
                MTX_RX_FRAME: begin
                    if (end_pend_reg) begin
                        rx_state_reg <= MTX_RX_IDLE;               // RL17
                    end
                end
                MTX_RX_FALSE: begin
                    if (!fc_pend_reg) begin
                        rx_state_reg <= MTX_RX_IDLE;
                    end
                end
                default: begin
                    rx_state_reg <= MTX_RX_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        rxer_next = 1'b0;
        if (speed) begin
            if (rx_state_reg == MTX_RX_FRAME && err_pend_reg) begin
                rxer_next = 1'b1;                                  // RL2
            end else if (rx_state_reg == MTX_RX_FALSE || fc_pend_reg) begin
                rxer_next = (rx_state_reg != MTX_RX_FRAME);        // RL3
            end
        end
    end

    // outputs move only with the rising receive clock
    always_ff @(posedge LINK_CLK or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            RXER_O <= 1'b0;
            RXDV_O <= 1'b0;
        end else if (rise) begin
            RXER_O <= rxer_next;                                   // RL1 RL4 RL18
            RXDV_O <= (rx_state_reg == MTX_RX_FRAME) ? !end_pend_reg : ssd_pend_reg && rx_state_reg == MTX_RX_IDLE;
        end
    end

    // enables follow the filtered request so a shared bus sees one driver
    always_ff @(posedge LINK_CLK or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            RXER_OE  <= 1'b0;
            RXDV_OE  <= 1'b0;
            RXCLK_OE <= 1'b0;
        end else begin
            RXER_OE  <= !tri_req;                                  // RL5
            RXDV_OE  <= !tri_req;                                  // RL6
            RXCLK_OE <= !tri_req;                                  // RL6
        end
    end

    // ---------------- checks ----------------
    default clocking link_cb @(posedge LINK_CLK); endclocking
    default disable iff (!lrst_n_reg);
    property p_rxer_quiet_10;
        !speed && $stable(speed) && rise |=> !RXER_O;
    endproperty
    a_rxer_quiet_10: assert property (p_rxer_quiet_10) // RL18
        else $error("rxer raised at ten megabit");
    property p_rxer_edge;
        !rise |=> $stable(RXER_O);
    endproperty
    a_rxer_edge: assert property (p_rxer_edge) // RL4
        else $error("rxer moved off the rxclk edge");
    property p_rxer_frame_err;
        rise && speed && rx_state_reg == MTX_RX_FRAME && err_pend_reg |=> RXER_O;
    endproperty
    a_rxer_frame_err: assert property (p_rxer_frame_err) // RL2
        else $error("frame error not flagged");
    property p_rxer_oe;
        tri_req |-> ##1 !RXER_OE ##0 !RXDV_OE;
    endproperty
    a_rxer_oe: assert property (p_rxer_oe) // RL5
        else $error("receive side driven under tristate");
    property p_halt;
        rise && TXEN && TXER && speed && !lcfg_reg[CFG_TEST] |=> TX_SYM == SYM_HALT;
    endproperty
    a_halt: assert property (p_halt) // RL14
        else $error("halt not substituted");
    property p_test_sym;
        rise && TXEN && TXER && speed && lcfg_reg[CFG_TEST]
            |=> TX_SYM == $past(lcfg_reg[CFG_SYM +: SYM_W]);
    endproperty
    a_test_sym: assert property (p_test_sym) // RL15
        else $error("test symbol not substituted");
    property p_txer_10;
        rise && TXEN && !speed |=> TX_SYM == {1'b0, $past(TXD)} && TX_SYM_VALID;
    endproperty
    a_txer_10: assert property (p_txer_10) // RL12
        else $error("nibble altered at ten megabit");
    property p_idle;
        rise && !TXEN |=> TX_SYM == SYM_IDLE && !TX_SYM_VALID;
    endproperty
    a_idle: assert property (p_idle) // RL19
        else $error("idle disturbed");
    // speed must hold one edge longer, the divider acts on it a cycle late
    property p_txclk_100;
        speed && $stable(speed) && $rose(TXCLK) ##1 speed |-> $fell(TXCLK) ##1 $rose(TXCLK);
    endproperty
    a_txclk_100: assert property (p_txclk_100) // RL7
        else $error("txclk not 25 MHz");
    property p_tx_end;
        rise && !TXEN |=> !TX_ON_LINE;
    endproperty
    a_tx_end: assert property (p_tx_end) // RL11
        else $error("transmission not ended");

    c_frame: cover property ($rose(RXDV_O) ##[1:200] $fell(RXDV_O));
    c_halt: cover property (TX_SYM_VALID && TX_SYM == SYM_HALT);
    c_false: cover property (rx_state_reg == MTX_RX_FALSE && RXER_O);
endmodule
`default_nettype wire

/* File: mtx_mac_model.sv */
// Purpose: mac side model driving the mii transmit inputs
// Assumes: phy samples on txclk rise, so the model moves on txclk fall
// Notes:   each stop inverts the idle data lines, so a second stop restores the last nibble
`timescale 1ns/1ns
`default_nettype none
module mtx_mac_model (
    input  wire logic                      TXCLK, // transmit clock from phy
    output var  logic                      TXEN,  // transmit enable
    output var  logic [mtx_pkg::NIB_W-1:0] TXD,   // transmit nibble
    output var  logic                      TXER   // transmit error
);
    import mtx_pkg::*;
    initial begin
        TXEN = 1'b0;
        TXD  = NIB_ZERO;
        TXER = 1'b0;
    end
    task automatic send(input logic [NIB_W-1:0] n, input logic e);
        @(negedge TXCLK);
        TXEN <= 1'b1;
        TXD  <= n;
        TXER <= e;
    endtask
    // idle lines carry no meaning, so each stop inverts the nibble left there
    task automatic stop(input logic e);
        @(negedge TXCLK);
        TXEN <= 1'b0;
        TXD  <= ~TXD;
        TXER <= e;
    endtask
endmodule
`default_nettype wire

/* File: mtx_mii_phy_tb_top.sv */
// Purpose: self-checking bench for the mii transmit / receive-error block
// Assumes: CLK 100 ns, LINK_CLK 80 ns with unrelated phase
// Notes:   rx events driven on LINK_CLK falls, config on CLK falls
`timescale 1ns/1ns
`default_nettype none
module mtx_mii_phy_tb_top;
    import mtx_pkg::*;
    localparam logic [SYM_W-1:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                             5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    logic             CLK = 1'b0;
    logic             LINK_CLK = 1'b0;
    logic             ARST_N = 1'b0;
    logic             SPEED_100 = 1'b1;
    logic             TEST_CODE_EN = 1'b0;
    logic [SYM_W-1:0] TEST_SYMBOL = SYM_ZERO;
    logic [4:0]       rx_ev = 5'h00;
    logic             RECEIVE_TRISTATE_REQUEST = 1'b0;
    logic             CFG_BUSY, TX_ACTIVE, TXCLK, TXEN, TXER, TX_SYM_VALID, TX_ON_LINE;
    logic [NIB_W-1:0] TXD;
    logic [SYM_W-1:0] TX_SYM;
    logic             RXCLK_O, RXCLK_OE, RXDV_O, RXDV_OE, RXER_O, RXER_OE;
    wire logic [4:0]  mon;
    logic [SYM_W-1:0] cap [$];
    logic             rxer_q = 1'b0;
    logic             rxclk_q = 1'b0;
    logic             act_q = 1'b0;
    int               act_rises = 0;
    int               fail_count = 0;
    int               check_count = 0;
    assign mon = {RXCLK_OE, RXDV_OE, RXER_OE, RXER_O, RXDV_O};

    initial forever #50 CLK = ~CLK;
    initial begin
        #17;
        forever #40 LINK_CLK = ~LINK_CLK;
    end

    mtx_mii_phy DUT (.CLK(CLK), .ARST_N(ARST_N), .SPEED_100(SPEED_100), .TEST_CODE_EN(TEST_CODE_EN),
        .TEST_SYMBOL(TEST_SYMBOL), .CFG_BUSY(CFG_BUSY), .TX_ACTIVE(TX_ACTIVE), .LINK_CLK(LINK_CLK),
        .TXCLK(TXCLK), .TXEN(TXEN), .TXD(TXD), .TXER(TXER), .TX_SYM(TX_SYM), .TX_SYM_VALID(TX_SYM_VALID),
        .TX_ON_LINE(TX_ON_LINE), .RX_SSD_DET(rx_ev[0]), .RX_ESD_DET(rx_ev[1]), .RX_SIG_ERR(rx_ev[2]),
        .RX_CODE_ERR(rx_ev[3]), .RX_FALSE_CAR(rx_ev[4]), .RECEIVE_TRISTATE_REQUEST(RECEIVE_TRISTATE_REQUEST),
        .RXCLK_O(RXCLK_O), .RXCLK_OE(RXCLK_OE), .RXDV_O(RXDV_O), .RXDV_OE(RXDV_OE), .RXER_O(RXER_O),
        .RXER_OE(RXER_OE));
    mtx_mac_model mac (.TXCLK(TXCLK), .TXEN(TXEN), .TXD(TXD), .TXER(TXER));

    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // samples land before the design's updates of the same edge
    always @(posedge LINK_CLK) begin
        if (TX_SYM_VALID === 1'b1 && TX_ON_LINE === 1'b1) begin
            cap.push_back(TX_SYM);
        end
        if (ARST_N === 1'b1 && RXER_O !== rxer_q) begin
            chk("rxer_edge", {rxclk_q, RXCLK_O}, 16'h0001);
        end
        rxer_q  <= RXER_O;
        rxclk_q <= RXCLK_O;
    end

    // counts transmit-busy rises seen on the management side
    always @(posedge CLK) begin
        act_q <= TX_ACTIVE;
        if (TX_ACTIVE === 1'b1 && act_q === 1'b0) begin
            act_rises <= act_rises + 1;
        end
    end

    task automatic set_cfg(input logic s, input logic t, input logic [SYM_W-1:0] y);
        int i;
        @(negedge CLK);
        SPEED_100 = s;
        TEST_CODE_EN = t;
        TEST_SYMBOL = y;
        repeat (2) @(negedge CLK);
        chk("cfg_busy_set", CFG_BUSY, 1'b1);
        for (i = 0; i < 50 && CFG_BUSY !== 1'b0; i++) @(negedge CLK);
        chk("cfg_busy_clr", CFG_BUSY, 1'b0);
        repeat (4) @(posedge LINK_CLK);
    endtask
    task automatic tx_frame(input int cnt, input logic [15:0] em, input logic idle_er);
        int i;
        int a0;
        logic [SYM_W-1:0] e;
        cap.delete();
        a0 = act_rises;
        for (i = 0; i < cnt; i++) mac.send(4'(i), em[i]);
        mac.stop(idle_er);
        repeat (4) @(posedge TXCLK);
        #1;
        chk("sym_count", 16'(cap.size()), 16'(cnt));
        for (i = 0; i < cnt; i++) begin
            e = !SPEED_100 ? {1'b0, 4'(i)} : !em[i] ? ENC[i] : TEST_CODE_EN ? TEST_SYMBOL : SYM_HALT;
            chk("tx_sym", cap[i], e);
        end
        chk("idle_sym", TX_SYM, SYM_IDLE);
        chk("on_line", TX_ON_LINE, 1'b0);
        mac.stop(1'b0);
        repeat (8) @(posedge CLK);
        chk("tx_active", TX_ACTIVE, 1'b0);
        chk("tx_active_rise", 16'(act_rises - a0), 16'h0001);
        $display("test tx frame of %0d done", cnt);
    endtask
    task automatic t_clk(input logic [DIV_W-1:0] half);
        time t0;
        @(posedge TXCLK);
        t0 = $time;
        @(posedge TXCLK);
        chk("txclk_per", 16'($time - t0), 16'(2 * half * 80));
        @(posedge RXCLK_O);
        t0 = $time;
        @(posedge RXCLK_O);
        chk("rxclk_per", 16'($time - t0), 16'(2 * half * 80));
        $display("test clock period done");
    endtask
    task automatic rx_pulse(input int k);
        @(negedge LINK_CLK);
        rx_ev[k] = 1'b1;
        @(negedge LINK_CLK);
        rx_ev[k] = 1'b0;
    endtask
    task automatic wcheck(input string nm, input int w, input logic v);
        int i;
        for (i = 0; i < 60 && mon[w] !== v; i++) @(posedge LINK_CLK);
        chk(nm, mon[w], v);
    endtask
    task automatic t_rx100;
        rx_pulse(0);
        wcheck("rxdv_set", 0, 1'b1);
        rx_pulse(3);
        wcheck("rxer_frame", 1, 1'b1);
        rx_pulse(1);
        wcheck("rxdv_end", 0, 1'b0);
        rx_pulse(0);
        wcheck("rxdv_set2", 0, 1'b1);
        rx_pulse(2);
        wcheck("rxdv_sigerr", 0, 1'b0);
        wcheck("rxer_idle", 1, 1'b0);
        rx_pulse(4);
        wcheck("rxer_false", 1, 1'b1);
        $display("test rx 100 done");
    endtask
    task automatic t_rx10;
        logic bad;
        bad = 1'b0;
        rx_pulse(0);
        wcheck("rxdv_10m", 0, 1'b1);
        rx_pulse(3);
        rx_pulse(4);
        repeat (60) begin
            @(posedge LINK_CLK);
            bad |= (RXER_O !== 1'b0);
        end
        chk("rxer_10m", bad, 1'b0);
        rx_pulse(1);
        wcheck("rxdv_10m_end", 0, 1'b0);
        $display("test rx 10 done");
    endtask
    task automatic t_tri;
        int w;
        for (w = 2; w < 5; w++) wcheck("oe_on", w, 1'b1);
        @(negedge LINK_CLK);
        RECEIVE_TRISTATE_REQUEST = 1'b1;
        for (w = 2; w < 5; w++) wcheck("oe_off", w, 1'b0);
        @(negedge LINK_CLK);
        RECEIVE_TRISTATE_REQUEST = 1'b0;
        for (w = 2; w < 5; w++) wcheck("oe_back", w, 1'b1);
        $display("test tristate done");
    endtask

    initial begin
        #500_000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(negedge CLK);
        ARST_N = 1'b1;
        repeat (4) @(negedge CLK);
        t_tri();
        tx_frame(16, 16'h0000, 1'b0);
        tx_frame(5, 16'h0012, 1'b1);
        t_clk(HALF_100);
        t_rx100();
        set_cfg(1'b1, 1'b1, 5'h19);
        tx_frame(4, 16'h0005, 1'b0);
        set_cfg(1'b0, 1'b0, SYM_ZERO);
        t_clk(HALF_10);
        tx_frame(6, 16'h003f, 1'b1);
        t_rx10();
        t_tri();
        report_and_stop();
    end
endmodule
`default_nettype wire
